// [pmsr_core.sv]
// Purpose: packed byte/halfword and Q15 rounding multiply unit
// Assumes: pipeline holds operands stable while issue is high
// Notes: one cycle latency, result and flags come from flip-flops
// What this block does
// - decode unsigned byte-by-halfword right multiply
// - right bytes times source_b halfwords, unsigned
// - keep 16 low bits, else clamp ffff
// - byte multiply saturation sets flag bit 21
// - base accumulator unpredictable, extras kept
// - only reserved or disabled exceptions
// - no operand-dependent exceptions ever
// - decode rounding Q15 vector multiply fields
// - signed halfword products shifted to Q31
// - add 8000 round, take bits 31..16
// - both 8000 inputs give 7fff
// - Q15 saturation sets flag bit 21
// - upper lanes high half, lower low
`include "pmsr_params.svh"
`default_nettype none
module pmsr_core (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// issue from the pipeline
	input wire logic issue,
	input wire logic [31:0] instr,
	input wire logic [31:0] source_a,
	input wire logic [31:0] source_b,
	input wire logic dsp_enable,
	input wire logic [31:0] dsp_control_in,
	// results to the register file
	output logic done,
	output logic dest_we,
	output logic [4:0] dest_addr,
	output logic [31:0] dest_data,
	output logic ctrl_we,
	output logic [31:0] dsp_control_out,
	output logic base_acc_clobber,
	output logic extra_acc_we,
	// exceptions
	output logic exc_reserved,
	output logic exc_dsp_disabled
);
	pmsr_pkg::pmsr_op_e op;
	logic pool_ok;
	logic q15;
	logic [15:0] hi_res;
	logic [15:0] lo_res;
	logic hi_sat;
	logic lo_sat;
	logic done_d, done_q;
	logic we_d, we_q;
	logic [4:0] addr_d, addr_q;
	logic [31:0] data_d, data_q;
	logic cwe_d, cwe_q;
	logic [31:0] ctl_d, ctl_q;
	logic clob_d, clob_q;
	logic rsv_d, rsv_q;
	logic dis_d, dis_q;

	always_comb
	begin
		pool_ok = (instr[`PMSR_MAJOR_HI:`PMSR_MAJOR_LO] == `PMSR_MAJOR_POOL)
			&& !instr[`PMSR_ZERO_BIT];
		op = pmsr_pkg::PMSR_OP_NONE;
		if (pool_ok
			&& instr[`PMSR_MINOR_HI:`PMSR_MINOR_LO] == `PMSR_MINOR_UBH)
			op = pmsr_pkg::PMSR_OP_UBH;
		else if (pool_ok
			&& instr[`PMSR_MINOR_HI:`PMSR_MINOR_LO] == `PMSR_MINOR_Q15R)
			op = pmsr_pkg::PMSR_OP_Q15R;
		q15 = (op == pmsr_pkg::PMSR_OP_Q15R);
	end

	// upper lane: byte 15..8 or halfword 31..16
	pmsr_lane u_hi (
		.q15_mode(q15),
		.a_half(source_a[31:16]),
		.a_byte(source_a[15:8]),
		.b_half(source_b[31:16]),
		.res(hi_res),
		.sat(hi_sat)
	);
	pmsr_lane u_lo (
		.q15_mode(q15),
		.a_half(source_a[15:0]),
		.a_byte(source_a[7:0]),
		.b_half(source_b[15:0]),
		.res(lo_res),
		.sat(lo_sat)
	);

	always_comb
	begin
		done_d = 1'b0;
		we_d = 1'b0;
		addr_d = addr_q;
		data_d = data_q;
		cwe_d = 1'b0;
		ctl_d = ctl_q;
		clob_d = 1'b0;
		rsv_d = 1'b0;
		dis_d = 1'b0;
		if (issue)
		begin
			done_d = 1'b1;
			unique case (op)
				pmsr_pkg::PMSR_OP_NONE:
					rsv_d = 1'b1;
				pmsr_pkg::PMSR_OP_UBH, pmsr_pkg::PMSR_OP_Q15R:
				begin
					// no operand value reaches an exception
					if (!dsp_enable)
						dis_d = 1'b1;
					else
					begin
						we_d = 1'b1;
						addr_d = instr[`PMSR_DEST_HI:`PMSR_DEST_LO];
						data_d = {hi_res, lo_res};
						cwe_d = 1'b1;
						ctl_d = dsp_control_in;
						if (hi_sat || lo_sat)
							ctl_d[`PMSR_SAT_BIT] = 1'b1;
						clob_d = 1'b1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			done_q <= 1'b0;
			we_q <= 1'b0;
			addr_q <= 5'h00;
			data_q <= 32'h00000000;
			cwe_q <= 1'b0;
			ctl_q <= 32'h00000000;
			clob_q <= 1'b0;
			rsv_q <= 1'b0;
			dis_q <= 1'b0;
		end
		else
		begin
			done_q <= done_d;
			we_q <= we_d;
			addr_q <= addr_d;
			data_q <= data_d;
			cwe_q <= cwe_d;
			ctl_q <= ctl_d;
			clob_q <= clob_d;
			rsv_q <= rsv_d;
			dis_q <= dis_d;
		end
	end

	// extra accumulators are never written
	logic extra_q;
	always_ff @(posedge mclk)
	begin
		extra_q <= 1'b0;
	end

	assign done = done_q;
	assign dest_we = we_q;
	assign dest_addr = addr_q;
	assign dest_data = data_q;
	assign ctrl_we = cwe_q;
	assign dsp_control_out = ctl_q;
	assign base_acc_clobber = clob_q;
	assign extra_acc_we = extra_q;
	assign exc_reserved = rsv_q;
	assign exc_dsp_disabled = dis_q;

	// checks
	property p_ubh_result;
		@(posedge mclk) disable iff (!rst_n)
		issue && dsp_enable && op == pmsr_pkg::PMSR_OP_UBH
			&& ({8'h00, source_a[7:0]} * source_b[15:0]) < 24'h010000
		|=> dest_data[15:0] == $past(source_a[7:0]) * $past(source_b[15:0]);
	endproperty
	a_ubh_result: assert property (p_ubh_result)
		else $error("byte lane product wrong");

	property p_ubh_sat;
		@(posedge mclk) disable iff (!rst_n)
		issue && dsp_enable && op == pmsr_pkg::PMSR_OP_UBH
			&& (source_a[15:8] * source_b[31:16]) > 24'h00ffff
		|=> dest_data[31:16] == 16'hffff && dsp_control_out[21];
	endproperty
	a_ubh_sat: assert property (p_ubh_sat)
		else $error("upper byte lane not clamped");

	property p_flag_when_sat;
		@(posedge mclk) disable iff (!rst_n)
		issue && dsp_enable && op != pmsr_pkg::PMSR_OP_NONE
			&& (hi_sat || lo_sat) |=> ctrl_we && dsp_control_out[21];
	endproperty
	a_flag_when_sat: assert property (p_flag_when_sat)
		else $error("saturation flag not set");

	property p_q15_neg1;
		@(posedge mclk) disable iff (!rst_n)
		issue && dsp_enable && op == pmsr_pkg::PMSR_OP_Q15R
			&& source_a[15:0] == 16'h8000 && source_b[15:0] == 16'h8000
		|=> dest_data[15:0] == 16'h7fff && dsp_control_out[21];
	endproperty
	a_q15_neg1: assert property (p_q15_neg1)
		else $error("q15 minus one case not clamped");

	property p_q15_round;
		@(posedge mclk) disable iff (!rst_n)
		issue && dsp_enable && op == pmsr_pkg::PMSR_OP_Q15R
			&& !(source_a[31:16] == 16'h8000 && source_b[31:16] == 16'h8000)
		|=> dest_data[31:16] == 16'(((32'($signed($past(source_a[31:16]))
			* $signed($past(source_b[31:16]))) <<< 1) + 32'h8000) >>> 16);
	endproperty
	a_q15_round: assert property (p_q15_round)
		else $error("q15 rounding wrong");

	property p_keep_flags;
		@(posedge mclk) disable iff (!rst_n)
		ctrl_we |-> dsp_control_out[20:0] == $past(dsp_control_in[20:0])
			&& (dsp_control_out[21] || !$past(dsp_control_in[21]));
	endproperty
	a_keep_flags: assert property (p_keep_flags)
		else $error("other control bits changed");

	property p_no_extra;
		@(posedge mclk) disable iff (!rst_n)
		done |-> !extra_acc_we && (base_acc_clobber == dest_we);
	endproperty
	a_no_extra: assert property (p_no_extra)
		else $error("accumulator handling wrong");

	property p_exc_only;
		@(posedge mclk) disable iff (!rst_n)
		issue && dsp_enable && op != pmsr_pkg::PMSR_OP_NONE
		|=> dest_we && !exc_reserved && !exc_dsp_disabled;
	endproperty
	a_exc_only: assert property (p_exc_only)
		else $error("data exception raised");

	property p_disabled;
		@(posedge mclk) disable iff (!rst_n)
		issue && !dsp_enable && op != pmsr_pkg::PMSR_OP_NONE
		|=> exc_dsp_disabled && !dest_we && !ctrl_we && !base_acc_clobber;
	endproperty
	a_disabled: assert property (p_disabled)
		else $error("disabled exception missing");

	property p_decode;
		@(posedge mclk) disable iff (!rst_n)
		issue && instr[31:26] == 6'h00 && !instr[10]
			&& instr[9:0] == 10'h0d5 |-> op == pmsr_pkg::PMSR_OP_UBH;
	endproperty
	a_decode: assert property (p_decode)
		else $error("byte multiply not decoded");

	c_ubh: cover property (@(posedge mclk) disable iff (!rst_n)
		issue && op == pmsr_pkg::PMSR_OP_UBH && hi_sat);
	c_q15: cover property (@(posedge mclk) disable iff (!rst_n)
		issue && op == pmsr_pkg::PMSR_OP_Q15R && lo_sat);
	c_rsv: cover property (@(posedge mclk) disable iff (!rst_n)
		issue ##1 exc_reserved);
endmodule : pmsr_core
`default_nettype wire

// [pmsr_lane.sv]
// Purpose: one halfword lane of both multiplies
// Assumes: combinational, mode chosen by the caller
// Notes: sat tells the caller this lane clamped
`include "pmsr_params.svh"
`default_nettype none
module pmsr_lane (
	// mode
	input wire logic q15_mode,
	// operands
	input wire logic [15:0] a_half,
	input wire logic [7:0] a_byte,
	input wire logic [15:0] b_half,
	// result
	output logic [15:0] res,
	output logic sat
);
	logic [23:0] uprod;
	logic signed [31:0] sprod;
	logic [31:0] q31;
	logic [31:0] rnd;
	logic both_neg1;
	always_comb
	begin
		uprod = {16'h0000, a_byte} * {8'h00, b_half};
		sprod = $signed(a_half) * $signed(b_half);
		q31 = {sprod[30:0], 1'b0};
		rnd = q31 + `PMSR_ROUND;
		both_neg1 = (a_half == `PMSR_Q15_NEG1) && (b_half == `PMSR_Q15_NEG1);
		if (q15_mode)
		begin
			sat = both_neg1;
			res = both_neg1 ? `PMSR_Q15_MAX : rnd[31:16];
		end
		else
		begin
			sat = |uprod[23:16];
			res = sat ? `PMSR_UBH_SAT : uprod[15:0];
		end
	end
endmodule : pmsr_lane
`default_nettype wire

// [pmsr_params.svh]
// Purpose: constants for the packed multiply datapath
// Assumes: 32-bit instruction words, core clock at 40 MHz
// Notes: definitions only
`ifndef PMSR_PARAMS_SVH
`define PMSR_PARAMS_SVH
`define PMSR_MAJOR_HI 31
`define PMSR_MAJOR_LO 26
`define PMSR_MAJOR_POOL 6'h00
`define PMSR_MINOR_HI 9
`define PMSR_MINOR_LO 0
`define PMSR_ZERO_BIT 10
`define PMSR_MINOR_UBH 10'h0d5
`define PMSR_MINOR_Q15R 10'h115
`define PMSR_SRCB_HI 25
`define PMSR_SRCB_LO 21
`define PMSR_SRCA_HI 20
`define PMSR_SRCA_LO 16
`define PMSR_DEST_HI 15
`define PMSR_DEST_LO 11
`define PMSR_SAT_BIT 21
`define PMSR_UBH_SAT 16'hffff
`define PMSR_Q15_NEG1 16'h8000
`define PMSR_Q15_MAX 16'h7fff
`define PMSR_ROUND 32'h00008000
`endif

// [pmsr_pipe_model.sv]
// Purpose: pipeline side model holding the control register
// Assumes: core writes back one cycle after issue
// Notes: a write in flight is forwarded to the next issue
`default_nettype none
module pmsr_pipe_model #(
	parameter logic [31:0] CTRL_INIT = 32'h0a000c03
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// write-back from the core
	input wire logic ctrl_we,
	input wire logic [31:0] dsp_control_out,
	// control value offered with issue
	output logic [31:0] dsp_control_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] ctrl_q;
	logic [31:0] ctrl_d;
	always_comb ctrl_d = ctrl_we ? dsp_control_out : ctrl_q;
	always_ff @(posedge mclk) ctrl_q <= rst_n ? ctrl_d : CTRL_INIT;
	// bypass so back-to-back issues see the newest flag
	assign dsp_control_in = ctrl_d;
	// base accumulator contents are never relied on here
endmodule : pmsr_pipe_model
`default_nettype wire

// [pmsr_pkg.sv]
// Purpose: types for the packed multiply datapath
// Assumes: nothing
// Notes: constants live in pmsr_params.svh
`default_nettype none
package pmsr_pkg;
	typedef enum logic [2:0] {
		PMSR_OP_NONE = 3'b001,
		PMSR_OP_UBH = 3'b010,
		PMSR_OP_Q15R = 3'b100
	} pmsr_op_e;
	typedef logic [15:0] pmsr_half_t;
endpackage : pmsr_pkg
`default_nettype wire

// [tb_packed_multiply_sat_round.sv]
// Purpose: self-checking bench for the packed multiply core
// Assumes: one cycle latency, exceptions pulse together with done
// Notes: expectations queued at issue, checked at the falling edge
`default_nettype none
module tb_packed_multiply_sat_round;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [1:0] kind;
		logic [4:0] rd;
		logic [31:0] data;
		logic [31:0] ctrl;
	} pmsr_tb_exp_s;
	localparam logic [31:0] INIT = 32'h0a000c03;
	logic mclk, rst_n, issue, dsp_enable, done, dest_we, ctrl_we;
	logic base_acc_clobber, extra_acc_we, exc_reserved, exc_dsp_disabled;
	logic [31:0] instr, source_a, source_b, dsp_control_in, dest_data;
	logic [31:0] dsp_control_out, exp_ctrl, seed;
	logic [4:0] dest_addr;
	int error_cnt, cmp_count, cyc;
	pmsr_tb_exp_s q[$];
	pmsr_core dut (.mclk(mclk), .rst_n(rst_n), .issue(issue),
		.instr(instr), .source_a(source_a), .source_b(source_b),
		.dsp_enable(dsp_enable), .dsp_control_in(dsp_control_in),
		.done(done), .dest_we(dest_we), .dest_addr(dest_addr),
		.dest_data(dest_data), .ctrl_we(ctrl_we),
		.dsp_control_out(dsp_control_out),
		.base_acc_clobber(base_acc_clobber), .extra_acc_we(extra_acc_we),
		.exc_reserved(exc_reserved), .exc_dsp_disabled(exc_dsp_disabled));
	pmsr_pipe_model #(.CTRL_INIT(INIT)) model (.mclk(mclk), .rst_n(rst_n),
		.ctrl_we(ctrl_we), .dsp_control_out(dsp_control_out),
		.dsp_control_in(dsp_control_in));
	initial
	begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	// returns {saturated, halfword}
	function automatic logic [16:0] f_lane(logic q, logic [15:0] a, b);
		logic [31:0] p;
		if (q)
		begin
			if (a == 16'h8000 && b == 16'h8000)
				return {1'b1, 16'h7fff};
			p = $signed(a) * $signed(b);
			p = (p << 1) + 32'h00008000;
			return {1'b0, p[31:16]};
		end
		p = 32'(a[7:0]) * 32'(b);
		return {|p[31:16], (|p[31:16]) ? 16'hffff : p[15:0]};
	endfunction : f_lane
	task check(logic [31:0] seen, logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task summarize();
		check(32'(q.size()), 32'h0);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : summarize
	task automatic go(logic [9:0] mn, logic [31:0] a, b, logic en,
		logic [5:0] maj = 6'h00, logic z = 1'b0);
		pmsr_tb_exp_s e;
		logic [16:0] hi, lo;
		logic q15;
		@(posedge mclk);
		e.rd = a[4:0] ^ b[9:5];
		issue <= 1'b1;
		instr <= {maj, 5'h07, 5'h0c, e.rd, z, mn};
		source_a <= a;
		source_b <= b;
		dsp_enable <= en;
		q15 = (mn == 10'h115);
		hi = f_lane(q15, q15 ? a[31:16] : {8'h00, a[15:8]}, b[31:16]);
		lo = f_lane(q15, q15 ? a[15:0] : {8'h00, a[7:0]}, b[15:0]);
		e.kind = (maj != 0 || z || (mn != 10'h0d5 && !q15)) ? 2'd1 :
			(en ? 2'd0 : 2'd2);
		if (e.kind == 0 && (hi[16] || lo[16]))
			exp_ctrl[21] = 1'b1;
		e.data = {hi[15:0], lo[15:0]};
		e.ctrl = exp_ctrl;
		q.push_back(e);
	endtask : go
	task idle();
		@(posedge mclk);
		issue <= 1'b0;
	endtask : idle
	task rst(int n);
		@(posedge mclk);
		rst_n <= 1'b0;
		issue <= 1'b0;
		repeat (n) @(posedge mclk);
		rst_n <= 1'b1;
		exp_ctrl = INIT;
	endtask : rst
	always @(negedge mclk)
	begin
		pmsr_tb_exp_s e;
		if (rst_n && (done || exc_reserved || exc_dsp_disabled))
		begin
			e = q.pop_front();
			check(32'(exc_reserved), 32'(e.kind == 1));
			check(32'(exc_dsp_disabled), 32'(e.kind == 2));
			check(32'(dest_we), 32'(e.kind == 0));
			check(32'(ctrl_we), 32'(e.kind == 0));
			check(32'(extra_acc_we), 32'h0);
			check(dsp_control_in, e.ctrl);
			if (e.kind == 0)
			begin
				check(dest_data, e.data);
				check(dsp_control_out, e.ctrl);
				check(32'(dest_addr), 32'(e.rd));
				check(32'(base_acc_clobber), 32'h1);
			end
		end
	end
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			error_cnt++;
			summarize();
		end
	end
	initial
	begin
		logic [31:0] r, a, b;
		seed = 32'd41;
		rst_n = 1'b0;
		issue = 1'b0;
		instr = 32'h0;
		source_a = 32'h0;
		source_b = 32'h0;
		dsp_enable = 1'b1;
		rst(20);
		go(10'h0d5, 32'h0000ff02, 32'h01018000, 1'b1);
		go(10'h0d5, 32'hffff1003, 32'h0ff00005, 1'b1);
		idle();
		rst(2);
		go(10'h115, 32'h80004000, 32'h8000c000, 1'b1);
		go(10'h115, 32'h00018000, 32'h00017fff, 1'b1);
		go(10'h115, 32'h40000001, 32'h00014000, 1'b1);
		go(10'h0d5, 32'h12345678, 32'h9abcdef0, 1'b0);
		go(10'h115, 32'h12345678, 32'h9abcdef0, 1'b0);
		go(10'h095, 32'h12345678, 32'h9abcdef0, 1'b1);
		go(10'h0d5, 32'h00000101, 32'h00010001, 1'b1, 6'h01);
		go(10'h115, 32'h00010001, 32'h00010001, 1'b1, 6'h00, 1'b1);
		idle();
		// operands always well formed for the chosen op
		repeat (300)
		begin
			r = xs();
			a = xs();
			b = xs();
			if (r[0])
				a[31:16] = 16'h8000;
			if (r[1])
				b[31:16] = 16'h8000;
			go(r[2] ? 10'h115 : 10'h0d5, a, b, r[7:3] != 0);
			if (r[8])
				idle();
		end
		idle();
		repeat (4) @(posedge mclk);
		summarize();
	end
endmodule : tb_packed_multiply_sat_round
`default_nettype wire
